// File: dual_buck_setpoint_control.sv
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Two-bit pairing code: 00/01 combined, 11 independent, 10 reserved.
// [R2] Combined pairing: first regulator controls; software mirrors its setup.
// [R3] Independent pairing: each output uses only its own registers.
// [R4] Range-select bit of normal set-point is read-only to host writes.
// [R5] Range bit comes from default configuration or programmed storage.
// [R6] Low range: 0.40 V plus 25 mV per code step.
// [R7] High range: 0.800 V plus 50 mV per step, at most 3.300 V; codes above it are flagged invalid, not limited.
// [R8] Software should use high range only for 2.00 V to 3.300 V.
// [R9] Normal, standby and sleep each hold a separate six-bit code.
// [R10] Initial range bit copied into standby and sleep set-points.
// [R11] Software must not program outputs at or below 0.6 V.
// [R12] A four-bit field selects each regulator's switching mode.
// [R13] For targets under 2.0 V software uses codes 0 to 63.
// [R14] Host set-point writes change only the low six bits.
// [R15] Reserved pairing code 10 is flagged as not valid.
module dual_buck_setpoint_control
   import buck_pair_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   input  wire logic       i_clk_en,
   input  wire logic [1:0] i_pairing_otp_code,
   input  wire logic       i_range_otp_programmed,
   input  wire logic       i_range_otp_value,
   input  wire op_mode_t   i_op_mode,
   input  wire buck_wr_t   i_wr_a,
   input  wire buck_wr_t   i_wr_b,
   output logic            o_pair_combined,
   output logic            o_pair_invalid,
   output buck_regs_t      o_regs_a,
   output buck_regs_t      o_regs_b,
   output buck_out_t       o_out_a,
   output buck_out_t       o_out_b
);

   // ************************************************************
   // Strap capture after reset release
   // ************************************************************
   logic       strap_done_ff;
   logic       nxt_strap_done;
   logic       range_ff;
   logic       nxt_range;
   logic [1:0] pairing_ff;
   logic [1:0] nxt_pairing;

   always_comb
   begin
      nxt_strap_done = 1'b1;
      nxt_range      = range_ff;
      nxt_pairing    = pairing_ff;
      if (!strap_done_ff)
      begin
         // [R5] Range source select.
         nxt_range   = i_range_otp_programmed ? i_range_otp_value
                                              : RANGE_DEFAULT;
         // [R1] Pairing code capture.
         nxt_pairing = i_pairing_otp_code;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         strap_done_ff <= 1'b0;
         range_ff      <= RANGE_DEFAULT;
         pairing_ff    <= PAIR_SINGLE_0;
      end
      else if (i_clk_en)
      begin
         strap_done_ff <= nxt_strap_done;
         range_ff      <= nxt_range;
         pairing_ff    <= nxt_pairing;
      end
   end

   // ************************************************************
   // Pairing decode
   // ************************************************************
   // [R1] Combined versus independent decode.
   assign o_pair_combined = (pairing_ff == PAIR_SINGLE_0) ||
                            (pairing_ff == PAIR_SINGLE_1);
   // [R15] Reserved code flagged.
   assign o_pair_invalid  = (pairing_ff == PAIR_RESERVED);

   // ************************************************************
   // Register banks for both regulators
   // ************************************************************
   buck_regs_t regs_a_ff;
   buck_regs_t regs_b_ff;
   buck_regs_t nxt_regs_a;
   buck_regs_t nxt_regs_b;

   function automatic buck_regs_t reg_update(buck_regs_t r, buck_wr_t w,
                                             logic first, logic rng);
      buck_regs_t n;
      n = r;
      // [R10] Range copied into all three set-points.
      if (first)
      begin
         n.normal[RANGE_POS]  = rng;
         n.standby[RANGE_POS] = rng;
         n.sleep[RANGE_POS]   = rng;
      end
      // [R4] [R14] Writes touch only the low six bits.
      if (w.wr_normal)
         n.normal[CODE_W-1:0] = w.code;
      // [R9] Separate standby and sleep codes.
      if (w.wr_standby)
         n.standby[CODE_W-1:0] = w.code;
      if (w.wr_sleep)
         n.sleep[CODE_W-1:0] = w.code;
      // [R12] Switching mode field.
      if (w.wr_mode)
         n.mode = w.mode;
      return n;
   endfunction

   always_comb
   begin
      // [R3] Each bank takes only its own write port.
      nxt_regs_a = reg_update(regs_a_ff, i_wr_a, !strap_done_ff, nxt_range);
      nxt_regs_b = reg_update(regs_b_ff, i_wr_b, !strap_done_ff, nxt_range);
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         regs_a_ff <= '{normal: {RANGE_DEFAULT, SETPOINT_RST},
                        standby: {RANGE_DEFAULT, SETPOINT_RST},
                        sleep: {RANGE_DEFAULT, SETPOINT_RST},
                        mode: MODE_RST};
         regs_b_ff <= '{normal: {RANGE_DEFAULT, SETPOINT_RST},
                        standby: {RANGE_DEFAULT, SETPOINT_RST},
                        sleep: {RANGE_DEFAULT, SETPOINT_RST},
                        mode: MODE_RST};
      end
      else if (i_clk_en)
      begin
         regs_a_ff <= nxt_regs_a;
         regs_b_ff <= nxt_regs_b;
      end
   end

   assign o_regs_a = regs_a_ff;
   assign o_regs_b = regs_b_ff;

   // ************************************************************
   // Active set-point and voltage
   // ************************************************************
   function automatic logic [6:0] pick(buck_regs_t r, op_mode_t m);
      logic [6:0] c;
      c = r.normal;
      case (m)
         OP_STANDBY: c = r.standby;
         OP_SLEEP:   c = r.sleep;
         default:    c = r.normal;
      endcase
      return c;
   endfunction

   function automatic logic [11:0] to_mv(logic [6:0] c);
      logic [11:0] v;
      // [R6] [R7] Low and high range steps.
      if (c[RANGE_POS])
         v = HIGH_BASE_MV + 12'(HIGH_STEP_MV * 12'(c[CODE_W-1:0]));
      else
         v = LOW_BASE_MV + 12'(LOW_STEP_MV * 12'(c[CODE_W-1:0]));
      return v;
   endfunction

   buck_out_t out_a_ff;
   buck_out_t out_b_ff;
   buck_out_t nxt_out_a;
   buck_out_t nxt_out_b;
   logic [6:0] code_a;
   logic [6:0] code_b;

   always_comb
   begin
      code_a = pick(regs_a_ff, i_op_mode);
      code_b = pick(regs_b_ff, i_op_mode);
      nxt_out_a.enable  = strap_done_ff && !o_pair_invalid;
      nxt_out_a.code    = code_a;
      nxt_out_a.mv      = to_mv(code_a);
      // [R7] Codes above the high-range ceiling are not valid.
      nxt_out_a.invalid = code_a[RANGE_POS] && (to_mv(code_a) > HIGH_MAX_MV);
      nxt_out_a.mode    = regs_a_ff.mode;
      // [R2] Combined pairing: second stage follows the first.
      nxt_out_b.enable  = strap_done_ff && !o_pair_invalid;
      nxt_out_b.code    = o_pair_combined ? code_a : code_b;
      nxt_out_b.mv      = o_pair_combined ? to_mv(code_a) : to_mv(code_b);
      nxt_out_b.invalid = nxt_out_b.code[RANGE_POS] &&
                          (nxt_out_b.mv > HIGH_MAX_MV);
      nxt_out_b.mode    = o_pair_combined ? regs_a_ff.mode : regs_b_ff.mode;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         out_a_ff <= '0;
         out_b_ff <= '0;
      end
      else if (i_clk_en)
      begin
         out_a_ff <= nxt_out_a;
         out_b_ff <= nxt_out_b;
      end
   end

   assign o_out_a = out_a_ff;
   assign o_out_b = out_b_ff;

   // ************************************************************
   // Checks
   // ************************************************************
   // [R4] Range bit fixed.
   a_range_ro_a: assert property ( // [R4]
      @(posedge i_sys_clk) disable iff (i_srst)
      (strap_done_ff && $past(strap_done_ff)) |->
      $stable(regs_a_ff.normal[RANGE_POS]))
      else $error("range bit of a changed");
   // [R10] Range copy check.
   a_range_copy: assert property ( // [R10]
      @(posedge i_sys_clk) disable iff (i_srst)
      strap_done_ff |-> (regs_a_ff.standby[RANGE_POS] == range_ff &&
      regs_b_ff.sleep[RANGE_POS] == range_ff))
      else $error("range bit not copied");
   // [R14] Low bits stored.
   a_low_only: assert property ( // [R14]
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_clk_en && i_wr_a.wr_normal && strap_done_ff) |=>
      regs_a_ff.normal[CODE_W-1:0] == $past(i_wr_a.code))
      else $error("normal code not stored");
   // [R3] Bank independence.
   a_indep_b: assert property ( // [R3]
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_clk_en && !i_wr_b.wr_standby && strap_done_ff) |=>
      $stable(regs_b_ff.standby))
      else $error("bank b changed without write");
   // [R6] Low range voltage.
   // The edge that leaves reset still clears the outputs, so it is skipped.
   a_low_volt: assert property ( // [R6]
      @(posedge i_sys_clk) disable iff (i_srst)
      (!i_srst && i_clk_en && !code_a[RANGE_POS]) |=>
      out_a_ff.mv == LOW_BASE_MV + 12'(LOW_STEP_MV * 12'($past(code_a[5:0]))))
      else $error("low range voltage wrong");
   // [R7] Ceiling flag check.
   a_high_cap: assert property ( // [R7]
      @(posedge i_sys_clk) disable iff (i_srst)
      out_a_ff.invalid == (out_a_ff.code[RANGE_POS] &&
      (12'(out_a_ff.code[CODE_W-1:0]) >
      12'((HIGH_MAX_MV - HIGH_BASE_MV) / HIGH_STEP_MV))))
      else $error("high range above ceiling");
   // [R1] Pairing decode.
   a_pair_dec: assert property ( // [R1]
      @(posedge i_sys_clk) disable iff (i_srst)
      o_pair_combined |-> (pairing_ff[1] == 1'b0))
      else $error("pairing decode wrong");
   // [R15] Reserved code disables.
   a_resv_flag: assert property ( // [R15]
      @(posedge i_sys_clk) disable iff (i_srst)
      (o_pair_invalid && i_clk_en) |=> !out_a_ff.enable)
      else $error("reserved pairing enabled output");
   // [R12] Mode field stored.
   a_mode_store: assert property ( // [R12]
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_clk_en && i_wr_b.wr_mode) |=> regs_b_ff.mode == $past(i_wr_b.mode))
      else $error("mode field not stored");

endmodule

// File: buck_pair_pkg.sv
package buck_pair_pkg;

   // ************************************************************
   // Pairing codes and field widths
   // ************************************************************
   localparam logic [1:0] PAIR_SINGLE_0 = 2'h0;
   localparam logic [1:0] PAIR_SINGLE_1 = 2'h1;
   localparam logic [1:0] PAIR_RESERVED = 2'h2;
   localparam logic [1:0] PAIR_INDEP    = 2'h3;
   localparam int         CODE_W        = 6;
   localparam int         RANGE_POS     = 6;
   localparam int         MODE_W        = 4;

   // ************************************************************
   // Reset values and voltage steps in millivolts
   // ************************************************************
   localparam logic [5:0]  SETPOINT_RST  = 6'h00;
   localparam logic [3:0]  MODE_RST      = 4'h0;
   localparam logic        RANGE_DEFAULT = 1'b0;
   localparam logic [11:0] LOW_BASE_MV   = 12'h190;
   localparam logic [11:0] LOW_STEP_MV   = 12'h019;
   localparam logic [11:0] HIGH_BASE_MV  = 12'h320;
   localparam logic [11:0] HIGH_STEP_MV  = 12'h032;
   localparam logic [11:0] HIGH_MAX_MV   = 12'hce4;

   typedef enum logic [1:0]
   {
      OP_NORMAL  = 2'b00,
      OP_STANDBY = 2'b01,
      OP_SLEEP   = 2'b10
   } op_mode_t;

   typedef struct packed
   {
      logic       wr_normal;
      logic       wr_standby;
      logic       wr_sleep;
      logic       wr_mode;
      logic [5:0] code;
      logic [3:0] mode;
   } buck_wr_t;

   typedef struct packed
   {
      logic [6:0] normal;
      logic [6:0] standby;
      logic [6:0] sleep;
      logic [3:0] mode;
   } buck_regs_t;

   typedef struct packed
   {
      logic        enable;
      logic [6:0]  code;
      logic [11:0] mv;
      logic        invalid;
      logic [3:0]  mode;
   } buck_out_t;

endpackage

// File: dual_buck_setpoint_control_tb.sv
`timescale 1ns/10ps
module dual_buck_setpoint_control_tb
   import buck_pair_pkg::*;
   ;
   // ************************************************************
   // Stimulus signals and design instance
   // ************************************************************
   typedef struct packed
   {
      op_mode_t   op;
      logic [5:0] ca;
      logic [5:0] cb;
   } row_t;

   logic       sys_clk   = 1'b0;
   logic       srst      = 1'b1;
   logic [1:0] pair_code = 2'h3;
   logic       rng_prog  = 1'b0;
   logic       rng_val   = 1'b0;
   logic       clk_en    = 1'b1;
   op_mode_t   op_mode   = OP_NORMAL;
   buck_wr_t   wr_a      = '0;
   buck_wr_t   wr_b      = '0;
   logic       pair_comb;
   logic       pair_inv;
   buck_regs_t regs_a;
   buck_regs_t regs_b;
   buck_out_t  out_a;
   buck_out_t  out_b;
   int         n_fail          = 0;
   int         samples_checked = 0;
   // Every code sits above 0.6 V, in the low range.
   row_t       rows [6] = '{'{OP_NORMAL, 6'h0a, 6'h3f},
      '{OP_STANDBY, 6'h09, 6'h0c}, '{OP_SLEEP, 6'h3f, 6'h15},
      '{OP_NORMAL, 6'h20, 6'h11}, '{OP_STANDBY, 6'h18, 6'h2a},
      '{OP_SLEEP, 6'h0b, 6'h30}};

   dual_buck_setpoint_control u_dual_buck_setpoint_control
   (
      .i_sys_clk              (sys_clk),
      .i_srst                 (srst),
      .i_clk_en               (clk_en),
      .i_pairing_otp_code     (pair_code),
      .i_range_otp_programmed (rng_prog),
      .i_range_otp_value      (rng_val),
      .i_op_mode              (op_mode),
      .i_wr_a                 (wr_a),
      .i_wr_b                 (wr_b),
      .o_pair_combined        (pair_comb),
      .o_pair_invalid         (pair_inv),
      .o_regs_a               (regs_a),
      .o_regs_b               (regs_b),
      .o_out_a                (out_a),
      .o_out_b                (out_b)
   );

   always #2 sys_clk = ~sys_clk;

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic conclude();
      if (n_fail == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Straps are only captured after reset, so every strap case resets.
   task automatic do_reset(input logic [1:0] p, input logic pr,
                           input logic v);
      @(posedge sys_clk);
      srst      <= 1'b1;
      pair_code <= p;
      rng_prog  <= pr;
      rng_val   <= v;
      repeat (4) @(posedge sys_clk);
      #1;
      chk("regs_a in reset", 32'h0, 32'(regs_a));
      chk("out_a in reset", 32'h0, 32'(out_a));
      @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   function automatic buck_wr_t mk(input op_mode_t op, input logic [5:0] c);
      buck_wr_t w;
      w            = '0;
      w.code       = c;
      w.wr_normal  = (op == OP_NORMAL);
      w.wr_standby = (op == OP_STANDBY);
      w.wr_sleep   = (op == OP_SLEEP);
      return w;
   endfunction

   function automatic logic [11:0] exp_mv(input logic r, input logic [5:0] c);
      if (r)
         return HIGH_BASE_MV + 12'(c) * HIGH_STEP_MV;
      return LOW_BASE_MV + 12'(c) * LOW_STEP_MV;
   endfunction

   // The strobe is dropped at the edge that takes it, so one write each.
   task automatic wr(input buck_wr_t wa, input buck_wr_t wb);
      @(posedge sys_clk);
      wr_a <= wa;
      wr_b <= wb;
      @(posedge sys_clk);
      wr_a <= '0;
      wr_b <= '0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial
   begin
      buck_wr_t ma;
      buck_wr_t mb;
      // Storage value 1 is ignored while storage is unprogrammed.
      do_reset(2'h3, 1'b0, 1'b1);
      foreach (rows[i])
      begin
         @(posedge sys_clk);
         op_mode <= rows[i].op;
         wr(mk(rows[i].op, rows[i].ca), mk(rows[i].op, rows[i].cb));
         chk("out_a.code", {25'h0, 1'b0, rows[i].ca}, 32'(out_a.code));
         chk("out_a.mv", 32'(exp_mv(1'b0, rows[i].ca)), 32'(out_a.mv));
         chk("out_b.code", {26'h0, rows[i].cb}, 32'(out_b.code));
         chk("out_b.mv", 32'(exp_mv(1'b0, rows[i].cb)), 32'(out_b.mv));
      end
      chk("regs_a codes", 32'h0080c0b, 32'({regs_a.normal, regs_a.standby,
         regs_a.sleep}));
      chk("regs_b codes", 32'h0045530, 32'({regs_b.normal, regs_b.standby,
         regs_b.sleep}));
      ma      = '0;
      mb      = '0;
      ma.wr_mode = 1'b1;
      mb.wr_mode = 1'b1;
      ma.mode = 4'h5;
      mb.mode = 4'ha;
      wr(ma, mb);
      chk("out_a.mode", 32'h5, 32'(out_a.mode));
      chk("regs_b.mode", 32'ha, 32'(regs_b.mode));
      chk("out_b.mode", 32'ha, 32'(out_b.mode));
      // Writes while the clock enable is low must leave every register alone.
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(mk(OP_NORMAL, 6'h2a), mk(OP_NORMAL, 6'h2a));
      chk("frozen regs_a.normal", 32'h20, 32'(regs_a.normal));
      chk("frozen regs_b.normal", 32'h11, 32'(regs_b.normal));
      @(posedge sys_clk);
      clk_en <= 1'b1;
      wr(mk(OP_STANDBY, 6'h2c), '0);
      chk("regs_a.standby", 32'h2c, 32'(regs_a.standby));
      chk("regs_b.standby", 32'h2a, 32'(regs_b.standby));
      do_reset(2'h0, 1'b1, 1'b1);
      chk("regs_a range", 32'h0102040, 32'({regs_a.normal, regs_a.standby,
         regs_a.sleep}));
      chk("regs_b range", 32'h0102040, 32'({regs_b.normal, regs_b.standby,
         regs_b.sleep}));
      @(posedge sys_clk);
      op_mode <= OP_NORMAL;
      // Both banks get the same top high-range code.
      wr(mk(OP_NORMAL, 6'h32), mk(OP_NORMAL, 6'h32));
      chk("regs_a.normal", 32'h72, 32'(regs_a.normal));
      chk("out_a.mv top", 32'hce4, 32'(out_a.mv));
      chk("out_a.invalid", 32'h0, 32'(out_a.invalid));
      chk("out_b mirror", 32'h72, 32'(out_b.code));
      chk("regs_b.normal", 32'h72, 32'(regs_b.normal));
      // A code past the ceiling, mirrored, must be flagged on both.
      wr(mk(OP_NORMAL, 6'h33), mk(OP_NORMAL, 6'h33));
      chk("out_a.invalid", 32'h1, 32'(out_a.invalid));
      chk("out_a.mv", 32'(exp_mv(1'b1, 6'h33)), 32'(out_a.mv));
      chk("out_b.invalid", 32'h1, 32'(out_b.invalid));
      chk("out_b.mv", 32'(exp_mv(1'b1, 6'h33)), 32'(out_b.mv));
      for (int p = 0; p < 4; p++)
      begin
         do_reset(2'(p), 1'b1, 1'b0);
         chk("pair_comb", 32'(p < 2), 32'(pair_comb));
         chk("pair_inv", 32'(p == 2), 32'(pair_inv));
         chk("out_a.enable", 32'(p != 2), 32'(out_a.enable));
         chk("out_b.enable", 32'(p != 2), 32'(out_b.enable));
         chk("regs_a.normal", 32'h0, 32'(regs_a.normal));
      end
      conclude();
   end

   // A hang would otherwise leave the verdict unprinted.
   initial
   begin
      #20000;
      n_fail = n_fail + 1;
      conclude();
   end
endmodule
